// ### hw/tpf_biphase_enc.sv
`timescale 1ns/10ps
module tpf_biphase_enc #(
  parameter int unsigned BIT_CYCLES  = tpf_pkg::BIT_CYCLES,
  parameter int unsigned HALF_CYCLES = tpf_pkg::HALF_CYCLES
) (
  input  logic clk,
  input  logic rst,
  input  logic cycle_tick,
  input  logic active,
  input  logic bit_in,
  output logic take,
  output logic bit_end,
  output logic busy,
  output logic mod_out
);
  import tpf_pkg::*;

  localparam int unsigned CNT_W = $clog2(BIT_CYCLES);
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] MID_CNT  = CNT_W'(HALF_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic             cur_r;
  logic             busy_r;
  logic             mod_r;
  logic             take_r;
  logic             end_r;

  // Next bit starts on the tick that ends the current one, so bits never gap
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      cur_r  <= 1'b0;
      busy_r <= 1'b0;
      mod_r  <= 1'b0;
      take_r <= 1'b0;
      end_r  <= 1'b0;
    end else begin
      take_r <= 1'b0;
      end_r  <= 1'b0;
      if (!busy_r) begin
        if (active) begin
          busy_r <= 1'b1;
          cur_r  <= bit_in;
          mod_r  <= ~mod_r;
          take_r <= 1'b1;
          cnt_r  <= '0;
        end
      end else if (cycle_tick) begin
        if (cnt_r == LAST_CNT) begin
          end_r <= 1'b1;
          if (active) begin
            cur_r  <= bit_in;
            mod_r  <= ~mod_r;
            take_r <= 1'b1;
            cnt_r  <= '0;
          end else begin
            busy_r <= 1'b0;
          end
        end else begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == MID_CNT && cur_r) begin
            mod_r <= ~mod_r;
          end
        end
      end
    end
  end

  assign take    = take_r;
  assign bit_end = end_r;
  assign busy    = busy_r;
  assign mod_out = mod_r;

endmodule

// ### hw/tpf_frame_shift.sv
`timescale 1ns/10ps
module tpf_frame_shift #(
  parameter int unsigned W     = tpf_pkg::FRAME_BITS,
  parameter int unsigned LEN_W = tpf_pkg::LEN_W
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             load,
  input  logic [W-1:0]     load_word,
  input  logic [LEN_W-1:0] load_len,
  input  logic             take,
  output logic             bit_out,
  output logic [LEN_W-1:0] remaining
);
  import tpf_pkg::*;

  logic [W-1:0]     word_r;
  logic [LEN_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= '0;
      cnt_r  <= '0;
    end else if (load) begin
      word_r <= load_word;
      cnt_r  <= load_len;
    end else if (take && cnt_r != '0) begin
      word_r <= word_r >> 1;
      cnt_r  <= cnt_r - 1'b1;
    end
  end

  assign bit_out   = word_r[0];
  assign remaining = cnt_r;

endmodule

// ### hw/tpf_framer.sv
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module tpf_framer #(
  parameter logic [3:0]  MAJOR_VER      = 4'h9,    // Arbitrary value
  parameter logic [3:0]  MINOR_VER      = 4'h4,    // Arbitrary value
  parameter logic [15:0] MAKER_CODE     = 16'h5a3c, // Arbitrary value
  parameter logic        FREQ_CTRL_HIPWR = 1'b0,
  parameter logic        PKT_RX_CAPABLE = 1'b0,
  parameter int unsigned BIT_CYCLES     = tpf_pkg::BIT_CYCLES,
  parameter int unsigned HALF_CYCLES    = tpf_pkg::HALF_CYCLES
) (
  input  logic                        clk,
  input  logic                        rst,
  input  logic [tpf_pkg::ADDR_W-1:0]  avs_address,
  input  logic                        avs_read,
  input  logic                        avs_write,
  input  logic [31:0]                 avs_writedata,
  input  logic [3:0]                  avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  logic                        power_cycle_tick,
  input  logic                        reduced_power,
  output logic                        fsk_mod,
  output logic                        tx_busy,
  output logic                        tx_done
);
  import tpf_pkg::*;

  function automatic logic [FRAME_BITS-1:0] byte_frame(input logic [7:0] d);
    byte_frame = {1'b1, ^d, d, 1'b0};
  endfunction

  function automatic logic [7:0] reverse8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    reverse8 = r;
  endfunction

  // Bus slave state
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        req;
  logic        wr_acc;
  logic [31:0] rd_mux;

  // Software registers
  logic [5:0]  gp_norm_r;
  logic [5:0]  gp_red_r;
  logic [5:0]  pp_r;
  logic        pkt_flag_r;
  logic        sens_flag_r;
  logic [2:0]  last_cmd_r;
  logic        done_st_r;
  logic        refused_st_r;
  logic [7:0]  last_chk_r;
  logic [15:0] pkt_cnt_r;
  logic [15:0] resp_cnt_r;

  // Transmit path
  tpf_state_t                state_r;
  logic [7:0]                buf_r [MAX_BYTES];
  logic [2:0]                nbytes_r;
  logic [2:0]                idx_r;
  logic                      is_resp_r;
  logic                      tx_busy_r;
  logic                      tx_done_r;
  logic                      cmd_wr;
  logic                      cmd_valid;
  logic                      accept;
  logic                      refuse;
  logic                      sh_load;
  logic [FRAME_BITS-1:0]     sh_word;
  logic [LEN_W-1:0]          sh_len;
  logic [LEN_W-1:0]          sh_remaining;
  logic                      sh_bit;
  logic                      enc_take;
  logic                      enc_end;
  logic                      enc_busy;
  logic                      finish;

  // Message assembly
  logic [7:0]  m_hdr;
  logic [7:0]  m_b0;
  logic [7:0]  m_b1;
  logic [7:0]  m_b2;
  logic [7:0]  m_chk;
  logic [7:0]  m_resp;
  logic [2:0]  m_len;
  logic        m_is_resp;
  logic [5:0]  gp_sel;
  logic        pkt_eff;
  logic        sens_eff;

  // One wait state per access; read data is registered beforehand
  assign req    = avs_read | avs_write;
  assign wr_acc = avs_write && !wait_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (req) begin
      wait_r <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      OFF_CMD: begin
        rd_mux[2:0] = last_cmd_r;
      end
      OFF_STATUS: begin
        rd_mux[ST_BUSY]    = tx_busy_r;
        rd_mux[ST_DONE]    = done_st_r;
        rd_mux[ST_REFUSED] = refused_st_r;
        rd_mux[ST_REDUCED] = reduced_power;
        rd_mux[10:8]       = idx_r;
      end
      OFF_CAP_NORM: begin
        rd_mux[5:0]                     = gp_norm_r;
        rd_mux[CAP_PP_LSB +: 6]         = pp_r;
        rd_mux[CAP_PKT]                 = pkt_flag_r;
        rd_mux[CAP_SENS]                = sens_flag_r;
      end
      OFF_CAP_RED: begin
        rd_mux[5:0] = gp_red_r;
      end
      OFF_LAST_CHK: begin
        rd_mux[7:0] = last_chk_r;
      end
      OFF_COUNT: begin
        rd_mux = {resp_cnt_r, pkt_cnt_r};
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (req && wait_r) begin
      rdata_r <= rd_mux;
    end
  end

  // Capability values; the reduced one applies while the limit input is high
  always_ff @(posedge clk) begin
    if (rst) begin
      gp_norm_r   <= GP_RST;
      gp_red_r    <= GP_RST;
      pp_r        <= PP_RST;
      pkt_flag_r  <= 1'b0;
      sens_flag_r <= 1'b0;
    end else if (wr_acc) begin
      if (avs_address == OFF_CAP_NORM) begin
        if (avs_byteenable[0]) begin
          gp_norm_r <= avs_writedata[5:0];
        end
        if (avs_byteenable[1]) begin
          pp_r <= avs_writedata[CAP_PP_LSB +: 6];
        end
        if (avs_byteenable[2]) begin
          pkt_flag_r  <= avs_writedata[CAP_PKT];
          sens_flag_r <= avs_writedata[CAP_SENS];
        end
      end
      if (avs_address == OFF_CAP_RED && avs_byteenable[0]) begin
        gp_red_r <= avs_writedata[5:0];
      end
    end
  end

  assign cmd_wr    = wr_acc && avs_address == OFF_CMD && avs_byteenable[0];
  assign cmd_valid = avs_writedata[2:0] <= 3'(TPF_CMD_NOT_DEF);
  assign accept    = cmd_wr && cmd_valid && state_r == TPF_IDLE;
  assign refuse    = cmd_wr && !accept;

  // Sampled at accept, so a cleared limit shows in the next packet
  assign gp_sel   = reduced_power ? gp_red_r : gp_norm_r;
  assign pkt_eff  = pkt_flag_r & PKT_RX_CAPABLE;
  assign sens_eff = sens_flag_r & ~FREQ_CTRL_HIPWR;

  always_comb begin
    m_hdr     = HDR_NO_DATA;
    m_b0      = 8'h00;
    m_b1      = 8'h00;
    m_b2      = 8'h00;
    m_resp    = RESP_NAK;
    m_len     = 3'h3;
    m_is_resp = 1'b0;
    case (tpf_cmd_t'(avs_writedata[2:0]))
      TPF_CMD_NO_DATA: begin
        m_hdr = HDR_NO_DATA;
        m_b0  = 8'h00;
        m_len = 3'h3;
      end
      TPF_CMD_IDENT: begin
        m_hdr = HDR_IDENT;
        m_b0  = {MAJOR_VER, MINOR_VER};
        m_b1  = MAKER_CODE[15:8];
        m_b2  = MAKER_CODE[7:0];
        m_len = 3'h5;
      end
      TPF_CMD_CAP: begin
        m_hdr = HDR_CAP;
        m_b0  = {CLASS_VAL, gp_sel};
        m_b1  = {2'h0, pp_r};
        m_b2  = {6'h00, pkt_eff, sens_eff};
        m_len = 3'h5;
      end
      TPF_CMD_ACK: begin
        m_resp    = RESP_ACK;
        m_is_resp = 1'b1;
        m_len     = 3'h1;
      end
      TPF_CMD_NAK: begin
        m_resp    = RESP_NAK;
        m_is_resp = 1'b1;
        m_len     = 3'h1;
      end
      TPF_CMD_NOT_DEF: begin
        m_resp    = RESP_NOT_DEF;
        m_is_resp = 1'b1;
        m_len     = 3'h1;
      end
      default: begin
        m_len = 3'h3;
      end
    endcase
  end

  // Unused bytes are zero, so one XOR serves every length
  assign m_chk = m_hdr ^ m_b0 ^ m_b1 ^ m_b2;

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < MAX_BYTES; i++) begin
        buf_r[i] <= 8'h00;
      end
      nbytes_r   <= 3'h0;
      is_resp_r  <= 1'b0;
      last_cmd_r <= 3'h0;
    end else if (accept) begin
      last_cmd_r <= avs_writedata[2:0];
      nbytes_r   <= m_len;
      is_resp_r  <= m_is_resp;
      buf_r[0]   <= m_is_resp ? m_resp : m_hdr;
      buf_r[1]   <= m_b0;
      if (m_len == 3'h3) begin
        buf_r[2] <= m_chk;
        buf_r[3] <= 8'h00;
        buf_r[4] <= 8'h00;
      end else begin
        buf_r[2] <= m_b1;
        buf_r[3] <= m_b2;
        buf_r[4] <= m_chk;
      end
    end
  end

  // Next frame is loaded while the last bit of the previous one is still on air
  assign finish = state_r == TPF_DRAIN && enc_end;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= TPF_IDLE;
      idx_r     <= 3'h0;
      tx_busy_r <= 1'b0;
      tx_done_r <= 1'b0;
    end else begin
      tx_done_r <= 1'b0;
      case (state_r)
        TPF_IDLE: begin
          if (accept) begin
            idx_r     <= 3'h0;
            tx_busy_r <= 1'b1;
            state_r   <= TPF_LOAD;
          end
        end
        TPF_LOAD: begin
          idx_r   <= idx_r + 1'b1;
          state_r <= TPF_WAIT;
        end
        TPF_WAIT: begin
          if (sh_remaining == '0) begin
            state_r <= (idx_r < nbytes_r) ? TPF_LOAD : TPF_DRAIN;
          end
        end
        TPF_DRAIN: begin
          if (finish) begin
            tx_done_r <= 1'b1;
            tx_busy_r <= 1'b0;
            state_r   <= TPF_IDLE;
          end
        end
        default: begin
          state_r <= TPF_IDLE;
        end
      endcase
    end
  end

  assign sh_load = state_r == TPF_LOAD;
  // Responses go out MSB first with no framing bits
  assign sh_word = is_resp_r ? {3'h0, reverse8(buf_r[0])} : byte_frame(buf_r[idx_r]);
  assign sh_len  = is_resp_r ? RESP_LEN : BYTE_LEN;

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      done_st_r    <= 1'b0;
      refused_st_r <= 1'b0;
    end else begin
      done_st_r    <= finish | (done_st_r &
                      ~(wr_acc && avs_address == OFF_STATUS && avs_byteenable[0] && avs_writedata[ST_DONE]));
      refused_st_r <= refuse | (refused_st_r &
                      ~(wr_acc && avs_address == OFF_STATUS && avs_byteenable[0] && avs_writedata[ST_REFUSED]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_chk_r <= 8'h00;
      pkt_cnt_r  <= CNT_RST;
      resp_cnt_r <= CNT_RST;
    end else if (finish) begin
      if (is_resp_r) begin
        resp_cnt_r <= resp_cnt_r + 1'b1;
      end else begin
        pkt_cnt_r  <= pkt_cnt_r + 1'b1;
        last_chk_r <= buf_r[nbytes_r - 1'b1];
      end
    end
  end

  tpf_frame_shift #(
    .W     (FRAME_BITS),
    .LEN_W (LEN_W)
  ) u_shift (
    .clk       (clk),
    .rst       (rst),
    .load      (sh_load),
    .load_word (sh_word),
    .load_len  (sh_len),
    .take      (enc_take),
    .bit_out   (sh_bit),
    .remaining (sh_remaining)
  );

  tpf_biphase_enc #(
    .BIT_CYCLES  (BIT_CYCLES),
    .HALF_CYCLES (HALF_CYCLES)
  ) u_enc (
    .clk        (clk),
    .rst        (rst),
    .cycle_tick (power_cycle_tick),
    .active     (sh_remaining != '0),
    .bit_in     (sh_bit),
    .take       (enc_take),
    .bit_end    (enc_end),
    .busy       (enc_busy),
    .mod_out    (fsk_mod)
  );

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_busy         = tx_busy_r;
  assign tx_done         = tx_done_r;

endmodule

// ### hw/tpf_pkg.sv
package tpf_pkg;

  // Bit timing in power-signal cycles
  localparam int unsigned BIT_CYCLES  = 512;
  localparam int unsigned HALF_CYCLES = 256;

  // Frame shapes
  localparam int unsigned FRAME_BITS = 11;
  localparam int unsigned LEN_W      = 4;
  localparam logic [3:0]  BYTE_LEN   = 4'hb;
  localparam logic [3:0]  RESP_LEN   = 4'h8;
  localparam int unsigned MAX_BYTES  = 5;

  // Packet headers
  localparam logic [7:0] HDR_NO_DATA = 8'h00;
  localparam logic [7:0] HDR_IDENT   = 8'h30;
  localparam logic [7:0] HDR_CAP     = 8'h31;

  // Response patterns, written as sent, most significant bit first
  localparam logic [7:0] RESP_ACK     = 8'hff;
  localparam logic [7:0] RESP_NAK     = 8'h00;
  localparam logic [7:0] RESP_NOT_DEF = 8'h55;

  localparam logic [1:0] CLASS_VAL = 2'h0;

  // Register byte addresses
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_CAP_NORM = 8'h08;
  localparam logic [7:0]  OFF_CAP_RED  = 8'h0c;
  localparam logic [7:0]  OFF_LAST_CHK = 8'h10;
  localparam logic [7:0]  OFF_COUNT    = 8'h14;

  // Field positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_REFUSED = 2;
  localparam int unsigned ST_REDUCED = 3;
  localparam int unsigned CAP_PP_LSB = 8;
  localparam int unsigned CAP_PKT    = 16;
  localparam int unsigned CAP_SENS   = 17;

  // Reset values
  localparam logic [5:0]  GP_RST  = 6'h00;
  localparam logic [5:0]  PP_RST  = 6'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    TPF_CMD_NO_DATA,
    TPF_CMD_IDENT,
    TPF_CMD_CAP,
    TPF_CMD_ACK,
    TPF_CMD_NAK,
    TPF_CMD_NOT_DEF
  } tpf_cmd_t;

  typedef enum logic [1:0] {
    TPF_IDLE,
    TPF_LOAD,
    TPF_WAIT,
    TPF_DRAIN
  } tpf_state_t;

endpackage

// ### testbench/tpf_framer_properties.sv
`timescale 1ns/10ps
module tpf_framer_properties
  import tpf_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = tpf_pkg::BIT_CYCLES
) (
  input logic                       clk,
  input logic                       rst,
  input logic [tpf_pkg::ADDR_W-1:0] avs_address,
  input logic                       avs_read,
  input logic                       avs_write,
  input logic [31:0]                avs_writedata,
  input logic [3:0]                 avs_byteenable,
  input logic [31:0]                avs_readdata,
  input logic                       avs_waitrequest,
  input logic                       power_cycle_tick,
  input logic                       reduced_power,
  input logic                       fsk_mod,
  input logic                       tx_busy,
  input logic                       tx_done
);
  localparam int L8  = 8 * BIT_CYCLES;
  localparam int L33 = 33 * BIT_CYCLES;
  localparam int L55 = 55 * BIT_CYCLES;
  // Ticks seen while busy; one tick of slack for the untimed start
  logic [15:0] tk_r;
  always_ff @(posedge clk) begin
    if (rst || !tx_busy) tk_r <= 16'h0000;
    else if (power_cycle_tick) tk_r <= tk_r + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_req |=> s_ans; endproperty
  property p_wait_idle; !$past(avs_read || avs_write) |-> avs_waitrequest; endproperty
  property p_unmapped; avs_read && avs_waitrequest && avs_address > OFF_COUNT |=> avs_readdata == 32'h0; endproperty
  property p_done_pulse; tx_done |=> !tx_done; endproperty
  property p_busy_done; tx_done |-> !tx_busy && $past(tx_busy); endproperty
  property p_mod_busy; $changed(fsk_mod) |-> tx_busy; endproperty
  property p_mod_tick; $changed(fsk_mod) && $past(tx_busy, 3) |-> $past(power_cycle_tick); endproperty
  property p_len;
    tx_done |-> (tk_r + 1 >= L8 && tk_r <= L8 + 1) || (tk_r + 1 >= L33 && tk_r <= L33 + 1)
             || (tk_r + 1 >= L55 && tk_r <= L55 + 1);
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one wait state");
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  a_busy_done: assert property (p_busy_done) else $error("busy not ending with done");
  a_mod_busy: assert property (p_mod_busy) else $error("modulation change while idle");
  a_mod_tick: assert property (p_mod_tick) else $error("transition off a tick");
  a_len: assert property (p_len) else $error("transfer length wrong");
endmodule

// ### testbench/tpf_framer_test.sv
`timescale 1ns/10ps
module tpf_framer_test;
  import tpf_pkg::*;
  localparam int unsigned BITC  = 8;
  localparam int unsigned HALFC = 4;
  localparam logic [3:0]  MAJ   = 4'h7;     // Arbitrary value
  localparam logic [3:0]  MIN   = 4'h3;     // Arbitrary value
  localparam logic [15:0] MAKER = 16'hc3a5; // Arbitrary value
  logic        clk, rst, avs_read, avs_write, reduced_power, mdl_clear;
  logic        power_cycle_tick = 1'b0;
  logic        avs_waitrequest, fsk_mod, tx_busy, tx_done, mdl_bad;
  logic [7:0]  avs_address, mdl_nbits, exp_n;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [63:0] mdl_bits, exp_bits;
  logic [1:0]  div_r = 2'h0;
  int          num_errors, check_count, k;

  // Flags forced off by parameters, whatever the register holds
  tpf_framer #(.MAJOR_VER(MAJ), .MINOR_VER(MIN), .MAKER_CODE(MAKER), .FREQ_CTRL_HIPWR(1'b1),
    .PKT_RX_CAPABLE(1'b0), .BIT_CYCLES(BITC), .HALF_CYCLES(HALFC)) tpf_framer_inst (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_cycle_tick(power_cycle_tick), .reduced_power(reduced_power),
    .fsk_mod(fsk_mod), .tx_busy(tx_busy), .tx_done(tx_done));
  tpf_rx_model #(.BIT_CYCLES(BITC), .HALF_CYCLES(HALFC)) tpf_rx_model_inst (
    .clk(clk), .rst(rst), .fsk_mod(fsk_mod), .power_cycle_tick(power_cycle_tick), .clear(mdl_clear),
    .nbits(mdl_nbits), .bits(mdl_bits), .bad(mdl_bad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    power_cycle_tick <= (div_r == 2'h3);
  end

  task results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      results();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    av(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [7:0] a);
    av(1'b0, a, 32'h0, 4'hf);
  endtask
  task push_bit(input logic b);
    exp_bits = {exp_bits[62:0], b};
    exp_n++;
  endtask
  task push_byte(input logic [7:0] b);
    push_bit(1'b0);
    for (int i = 0; i < 8; i++) push_bit(b[i]);
    push_bit(^b);
    push_bit(1'b1);
  endtask
  // n = 0: response pattern h; else packet with n message bytes
  task run_cmd(input logic [2:0] code, input logic [7:0] h, b0, b1, b2, input int n, input logic poke);
    logic [7:0] c;
    int i;
    c = h ^ b0 ^ b1 ^ b2;
    exp_bits = 64'h0;
    exp_n = 8'h0;
    if (n == 0) for (i = 7; i >= 0; i--) push_bit(h[i]);
    else begin
      push_byte(h);
      push_byte(b0);
      if (n > 1) begin
        push_byte(b1);
        push_byte(b2);
      end
      push_byte(c);
    end
    mdl_clear <= 1'b1;
    @(posedge clk);
    mdl_clear <= 1'b0;
    wr(OFF_CMD, {29'h0, code});
    if (poke) begin
      wr(OFF_CMD, 32'h4);
      rd(OFF_STATUS);
      check("refused busy", 2'h3, {q[ST_REFUSED], q[ST_BUSY]});
    end
    i = 0;
    while (tx_done !== 1'b1 && i < 5000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 5000) begin
      num_errors++;
      results();
    end
    repeat (4) @(posedge clk);
    check("frame bits", exp_bits, mdl_bits);
    check("frame length", exp_n, mdl_nbits);
    check("bit timing", 1'b0, mdl_bad);
    if (n > 0) begin
      rd(OFF_LAST_CHK);
      check("checksum", c, q[7:0]);
    end
  endtask

  initial begin
    {rst, avs_read, avs_write, reduced_power, mdl_clear} = 5'h10;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_STATUS);
    check("status reset", 32'h0, q);
    rd(OFF_COUNT);
    check("count reset", 32'h0, q);
    rd(8'h40);
    check("unmapped read", 32'h0, q);
    wr(OFF_CAP_NORM, 32'h0003181e);
    wr(OFF_CAP_RED, 32'h0000000a);
    av(1'b1, OFF_CAP_RED, 32'h0000ff3f, 4'h2);
    rd(OFF_CAP_RED);
    check("lane ignored", 32'h0000000a, q);
    $display("test registers done");
    run_cmd(3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1'b0);
    run_cmd(3'h1, 8'h30, {MAJ, MIN}, MAKER[15:8], MAKER[7:0], 3, 1'b0);
    reduced_power <= 1'b1;
    rd(OFF_STATUS);
    check("reduced live", 1'b1, q[ST_REDUCED]);
    run_cmd(3'h2, 8'h31, 8'h0a, 8'h18, 8'h00, 3, 1'b0);
    reduced_power <= 1'b0;
    run_cmd(3'h2, 8'h31, 8'h1e, 8'h18, 8'h00, 3, 1'b0);
    for (k = 3; k < 6; k++)
      run_cmd(k[2:0], k == 3 ? 8'hff : k == 4 ? 8'h00 : 8'h55, 8'h0, 8'h0, 8'h0, 0, k == 3);
    $display("test frames done");
    wr(OFF_STATUS, 32'h6);
    rd(OFF_STATUS);
    check("sticky cleared", 2'h0, q[2:1]);
    wr(OFF_CMD, 32'h7);
    rd(OFF_STATUS);
    check("bad code refused", 2'h2, {q[ST_REFUSED], q[ST_BUSY]});
    check("idle after bad code", 1'b0, tx_busy);
    rd(OFF_CMD);
    check("last code", 32'h5, q[2:0]);
    rd(OFF_COUNT);
    check("done counts", 32'h00030004, q);
    $display("test control done");
    results();
  end
endmodule

bind tpf_framer tpf_framer_properties #(.BIT_CYCLES(BIT_CYCLES)) chk_inst (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .power_cycle_tick(power_cycle_tick), .reduced_power(reduced_power),
  .fsk_mod(fsk_mod), .tx_busy(tx_busy), .tx_done(tx_done));

// ### testbench/tpf_rx_model.sv
`timescale 1ns/10ps
module tpf_rx_model #(
  parameter int unsigned BIT_CYCLES  = 8,
  parameter int unsigned HALF_CYCLES = 4
) (
  input  logic        clk,
  input  logic        rst,
  input  logic        fsk_mod,
  input  logic        power_cycle_tick,
  input  logic        clear,
  output logic [7:0]  nbits,
  output logic [63:0] bits,
  output logic        bad
);
  logic        prev_r, active_r, mid_r;
  logic [15:0] cnt_r;
  logic [1:0]  wait_r;
  logic        edge_w;
  assign edge_w = fsk_mod != prev_r;
  always_ff @(posedge clk) begin
    prev_r <= rst ? 1'b0 : fsk_mod;
    if (rst || clear) begin
      {active_r, mid_r, bad} <= 3'h0;
      cnt_r <= 16'h0;
      wait_r <= 2'h0;
      nbits <= 8'h0;
      bits <= 64'h0;
    end else if (!active_r) begin
      active_r <= edge_w;
      // The sender already counts a tick on the edge that shows its first toggle
      cnt_r <= {15'h0, power_cycle_tick};
      mid_r <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      if (power_cycle_tick) cnt_r <= cnt_r + 16'h1;
      // Mid-bit transition marks a one, bit edge closes the bit
      if (edge_w) begin
        if (cnt_r == HALF_CYCLES) mid_r <= 1'b1;
        else if (cnt_r == BIT_CYCLES) begin
          bits <= {bits[62:0], mid_r};
          nbits <= nbits + 8'h1;
          cnt_r <= 16'h0;
          mid_r <= 1'b0;
          wait_r <= 2'h0;
        end else bad <= 1'b1;
      end else if (cnt_r == BIT_CYCLES) begin
        // No next bit edge shortly after the count ran out: frame over
        if (wait_r == 2'h2) begin
          bits <= {bits[62:0], mid_r};
          nbits <= nbits + 8'h1;
          active_r <= 1'b0;
        end else wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule
